/* File: core/rmb_regs.svh */
`ifndef RMB_REGS_SVH
`define RMB_REGS_SVH

`define RMB_CLK_MHZ 250
`define RMB_HOLD_US 125
`define RMB_HOLD_CYC (`RMB_HOLD_US * `RMB_CLK_MHZ)
`define RMB_DEAD_NS 3000
`define RMB_DEAD_CYC ((`RMB_DEAD_NS * `RMB_CLK_MHZ) / 1000)
`define RMB_IPWM_PRESCALE 6'h25
`define RMB_HPWM_PRESCALE 6'h27
`define RMB_DIR_GAP_US 2500
`define RMB_DIR_GAP_CYC (`RMB_DIR_GAP_US * `RMB_CLK_MHZ)
`define RMB_DUTY_FULL 8'hFF
`define RMB_START_DUTY 8'h4D
`define RMB_START_PERIODS 5'h10

`endif

/* File: core/rmb_pkg.sv */
package rmb_pkg;

  typedef enum logic [1:0] {
    RMB_STANDBY,
    RMB_FORWARD,
    RMB_REVERSE,
    RMB_BRAKE
  } rmb_mode_e;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    rmb_mode_e mode;
    logic [15:0] hold_cnt;
    logic [9:0] dead_cnt;
    logic [5:0] pre_cnt;
    logic [7:0] duty_cnt;
    logic active;
    logic high_side_switch_a;
    logic low_side_switch_a;
    logic high_side_switch_b;
    logic low_side_switch_b;
    logic bridge_output_a_level;
    logic bridge_output_a_float;
    logic bridge_output_b_level;
    logic bridge_output_b_float;
  } rmb_dev_state_s;

  typedef struct packed {
    rmb_mode_e mode;
    logic [19:0] gap_cnt;
    logic [5:0] pre_cnt;
    logic [7:0] phase;
    logic [4:0] boost_cnt;
    logic forward_direction_input;
    logic reverse_direction_input;
  } rmb_host_state_s;

endpackage

/* File: core/rmb_link_if.sv */
`timescale 1ns/1ps
interface rmb_link_if;
  logic forward_direction_input;
  logic reverse_direction_input;

  modport dev
  (
    input forward_direction_input,
    input reverse_direction_input
  );

  modport host
  (
    output forward_direction_input,
    output reverse_direction_input
  );
endinterface

/* File: core/rmb_bridge_ctrl.sv */
`timescale 1ns/1ps
`include "rmb_regs.svh"
module rmb_bridge_ctrl #(
  parameter int HOLD_CYC = `RMB_HOLD_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  rmb_link_if.dev link,
  input wire logic [7:0] ref_ratio,
  output logic high_side_switch_a,
  output logic low_side_switch_a,
  output logic high_side_switch_b,
  output logic low_side_switch_b,
  output logic bridge_output_a_level,
  output logic bridge_output_a_float,
  output logic bridge_output_b_level,
  output logic bridge_output_b_float,
  output logic circuits_active,
  output rmb_pkg::rmb_mode_e mode_status
);

  localparam int DEAD_CYC = `RMB_DEAD_CYC;

  rmb_pkg::rmb_dev_state_s state_reg;
  rmb_pkg::rmb_dev_state_s state_next;

  logic forward_line;
  logic rev;
  logic ref_full;
  logic int_pwm;
  logic pulse_a;
  logic pulse_b;
  logic off;
  rmb_pkg::rmb_mode_e target;

  always_comb
  begin
    state_next = state_reg;
    // two-stage synchroniser, second stage only is decoded
    state_next.sync1 = {link.reverse_direction_input, link.forward_direction_input};
    state_next.sync2 = state_reg.sync1;
    forward_line = state_reg.sync2[0];
    rev = state_reg.sync2[1];
    ref_full = (ref_ratio == `RMB_DUTY_FULL);
    target = state_reg.mode;

    // mode decode
    if (forward_line && rev)
    begin
      target = rmb_pkg::RMB_BRAKE;
      state_next.hold_cnt = 16'h0000;
    end
    else if (forward_line)
    begin
      target = rmb_pkg::RMB_FORWARD;
      state_next.hold_cnt = 16'h0000;
    end
    else if (rev)
    begin
      target = rmb_pkg::RMB_REVERSE;
      state_next.hold_cnt = 16'h0000;
    end
    else if (state_reg.mode == rmb_pkg::RMB_BRAKE || state_reg.mode == rmb_pkg::RMB_STANDBY)
    begin
      target = rmb_pkg::RMB_STANDBY;
      state_next.hold_cnt = 16'h0000;
    end
    else if (int'(state_reg.hold_cnt) >= HOLD_CYC - 1)
    begin
      target = rmb_pkg::RMB_STANDBY;
      state_next.hold_cnt = 16'h0000;
    end
    else
    begin
      // previous forward or reverse mode kept while both lines are low, for up to HOLD_CYC cycles
      target = state_reg.mode;
      state_next.hold_cnt = state_reg.hold_cnt + 16'h0001;
    end

    // dead time between two driven modes
    if (target != state_reg.mode && state_reg.mode != rmb_pkg::RMB_STANDBY
        && target != rmb_pkg::RMB_STANDBY)
    begin
      state_next.dead_cnt = DEAD_CYC[9:0];
    end
    else if (target == rmb_pkg::RMB_STANDBY)
    begin
      state_next.dead_cnt = 10'h000;
    end
    else if (state_reg.dead_cnt != 10'h000)
    begin
      state_next.dead_cnt = state_reg.dead_cnt - 10'h001;
    end
    state_next.mode = target;
    state_next.active = (target != rmb_pkg::RMB_STANDBY);

    // internal duty oscillator, stopped in standby
    if (!state_next.active)
    begin
      state_next.pre_cnt = 6'h00;
      state_next.duty_cnt = 8'h00;
    end
    else if (state_reg.pre_cnt == `RMB_IPWM_PRESCALE - 6'h01)
    begin
      state_next.pre_cnt = 6'h00;
      state_next.duty_cnt = state_reg.duty_cnt + 8'h01;
    end
    else
    begin
      state_next.pre_cnt = state_reg.pre_cnt + 6'h01;
    end
    int_pwm = (state_reg.duty_cnt < ref_ratio);

    // full reference: low side follows the pulsed line
    pulse_a = ref_full ? forward_line : int_pwm;
    pulse_b = ref_full ? rev : int_pwm;
    off = (state_next.dead_cnt != 10'h000);

    // all four switches from one register update
    state_next.high_side_switch_a = 1'b0;
    state_next.low_side_switch_a = 1'b0;
    state_next.high_side_switch_b = 1'b0;
    state_next.low_side_switch_b = 1'b0;
    if (!off)
    begin
      case (target)
        rmb_pkg::RMB_FORWARD:
        begin
          state_next.high_side_switch_a = 1'b1;
          state_next.low_side_switch_a = pulse_a;
        end
        rmb_pkg::RMB_REVERSE:
        begin
          state_next.high_side_switch_b = 1'b1;
          state_next.low_side_switch_b = pulse_b;
        end
        rmb_pkg::RMB_BRAKE:
        begin
          state_next.low_side_switch_a = 1'b1;
          state_next.low_side_switch_b = 1'b1;
        end
        default:
        begin
          state_next.low_side_switch_a = 1'b0;
          state_next.low_side_switch_b = 1'b0;
        end
      endcase
    end

    // bridge output levels
    state_next.bridge_output_a_level = state_next.high_side_switch_a;
    state_next.bridge_output_a_float =
      !state_next.high_side_switch_a && !state_next.low_side_switch_a;
    state_next.bridge_output_b_level = state_next.high_side_switch_b;
    state_next.bridge_output_b_float =
      !state_next.high_side_switch_b && !state_next.low_side_switch_b;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '{
        sync1: 2'h0,
        sync2: 2'h0,
        mode: rmb_pkg::RMB_STANDBY,
        hold_cnt: 16'h0000,
        dead_cnt: 10'h000,
        pre_cnt: 6'h00,
        duty_cnt: 8'h00,
        active: 1'b0,
        high_side_switch_a: 1'b0,
        low_side_switch_a: 1'b0,
        high_side_switch_b: 1'b0,
        low_side_switch_b: 1'b0,
        bridge_output_a_level: 1'b0,
        bridge_output_a_float: 1'b1,
        bridge_output_b_level: 1'b0,
        bridge_output_b_float: 1'b1
      };
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign high_side_switch_a = state_reg.high_side_switch_a;
  assign low_side_switch_a = state_reg.low_side_switch_a;
  assign high_side_switch_b = state_reg.high_side_switch_b;
  assign low_side_switch_b = state_reg.low_side_switch_b;
  assign bridge_output_a_level = state_reg.bridge_output_a_level;
  assign bridge_output_a_float = state_reg.bridge_output_a_float;
  assign bridge_output_b_level = state_reg.bridge_output_b_level;
  assign bridge_output_b_float = state_reg.bridge_output_b_float;
  assign circuits_active = state_reg.active;
  assign mode_status = state_reg.mode;

endmodule

/* File: core/rmb_host_drive.sv */
`timescale 1ns/1ps
`include "rmb_regs.svh"
module rmb_host_drive #(
  parameter int DIR_GAP_CYC = `RMB_DIR_GAP_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  rmb_link_if.host link,
  input rmb_pkg::rmb_mode_e host_mode,
  input wire logic speed_pwm_en,
  input wire logic [7:0] speed_duty,
  output rmb_pkg::rmb_mode_e applied_mode
);

  rmb_pkg::rmb_host_state_s state_reg;
  rmb_pkg::rmb_host_state_s state_next;

  logic [7:0] duty;
  logic pulse;
  logic may_change;

  always_comb
  begin
    state_next = state_reg;
    // reference mode: direction changes spaced out
    may_change = speed_pwm_en || (state_reg.gap_cnt == 20'h00000);
    if (state_reg.gap_cnt != 20'h00000)
    begin
      state_next.gap_cnt = state_reg.gap_cnt - 20'h00001;
    end
    if (host_mode != state_reg.mode && may_change)
    begin
      state_next.mode = host_mode;
      state_next.gap_cnt = DIR_GAP_CYC[19:0];
      if ((host_mode == rmb_pkg::RMB_FORWARD || host_mode == rmb_pkg::RMB_REVERSE)
          && (state_reg.mode == rmb_pkg::RMB_STANDBY || state_reg.mode == rmb_pkg::RMB_BRAKE))
      begin
        state_next.boost_cnt = `RMB_START_PERIODS;
      end
    end

    // pulse generator near 25 kHz
    if (state_reg.pre_cnt == `RMB_HPWM_PRESCALE - 6'h01)
    begin
      state_next.pre_cnt = 6'h00;
      state_next.phase = state_reg.phase + 8'h01;
      if (state_reg.phase == 8'hFF && state_reg.boost_cnt != 5'h00)
      begin
        state_next.boost_cnt = state_reg.boost_cnt - 5'h01;
      end
    end
    else
    begin
      state_next.pre_cnt = state_reg.pre_cnt + 6'h01;
    end
    duty = speed_duty;
    if (state_reg.boost_cnt != 5'h00 && speed_duty < `RMB_START_DUTY)
    begin
      duty = `RMB_START_DUTY;
    end
    pulse = (duty == `RMB_DUTY_FULL) || (state_reg.phase < duty);

    // both lines change on one edge
    case (state_next.mode)
      rmb_pkg::RMB_FORWARD:
      begin
        state_next.forward_direction_input = speed_pwm_en ? pulse : 1'b1;
        state_next.reverse_direction_input = 1'b0;
      end
      rmb_pkg::RMB_REVERSE:
      begin
        state_next.forward_direction_input = 1'b0;
        state_next.reverse_direction_input = speed_pwm_en ? pulse : 1'b1;
      end
      rmb_pkg::RMB_BRAKE:
      begin
        state_next.forward_direction_input = 1'b1;
        state_next.reverse_direction_input = 1'b1;
      end
      default:
      begin
        state_next.forward_direction_input = 1'b0;
        state_next.reverse_direction_input = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '{
        mode: rmb_pkg::RMB_STANDBY,
        gap_cnt: 20'h00000,
        pre_cnt: 6'h00,
        phase: 8'h00,
        boost_cnt: 5'h00,
        forward_direction_input: 1'b0,
        reverse_direction_input: 1'b0
      };
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign link.forward_direction_input = state_reg.forward_direction_input;
  assign link.reverse_direction_input = state_reg.reverse_direction_input;
  assign applied_mode = state_reg.mode;

endmodule

/* File: verif/rmb_link_props.sv */
`timescale 1ns/1ps
`include "rmb_regs.svh"
module rmb_link_props #(
  parameter int HOLD_CYC = `RMB_HOLD_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic forward_direction_input,
  input wire logic reverse_direction_input,
  input wire logic [7:0] ref_ratio,
  input wire logic high_side_switch_a,
  input wire logic low_side_switch_a,
  input wire logic high_side_switch_b,
  input wire logic low_side_switch_b,
  input wire logic bridge_output_a_float,
  input wire logic bridge_output_b_float,
  input wire logic circuits_active,
  input rmb_pkg::rmb_mode_e mode_status
);
  logic [11:0] since_a_reg;
  logic [15:0] low_cnt_reg;
  logic both_low;
  logic any_on;
  assign both_low = !forward_direction_input && !reverse_direction_input;
  assign any_on = high_side_switch_a | low_side_switch_a | high_side_switch_b | low_side_switch_b;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // time since high side a was last on, and length of both-low run
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      since_a_reg <= 12'hFFF;
      low_cnt_reg <= 16'h0000;
    end
    else
    begin
      since_a_reg <= high_side_switch_a ? 12'h000
        : since_a_reg + {11'h000, since_a_reg != 12'hFFF};
      low_cnt_reg <= !both_low ? 16'h0000 : low_cnt_reg + {15'h0000, low_cnt_reg != 16'hFFFF};
    end
  end
  sequence s_a_rise;
    !high_side_switch_a ##1 high_side_switch_a;
  endsequence
  sequence s_forward_released;
    mode_status == rmb_pkg::RMB_FORWARD && both_low && low_cnt_reg == 16'h0001;
  endsequence
  AST_STANDBY_OFF: assert property (mode_status == rmb_pkg::RMB_STANDBY |-> !any_on
    && bridge_output_a_float && bridge_output_b_float) else $error("switch on in standby");
  AST_POWER: assert property (circuits_active == (mode_status != rmb_pkg::RMB_STANDBY))
    else $error("circuit power does not match mode");
  AST_FWD_PAT: assert property (mode_status == rmb_pkg::RMB_FORWARD |->
    !high_side_switch_b && !low_side_switch_b) else $error("leg b on in forward");
  AST_REV_PAT: assert property (mode_status == rmb_pkg::RMB_REVERSE |->
    !high_side_switch_a && !low_side_switch_a) else $error("leg a on in reverse");
  AST_BRAKE_PAT: assert property (mode_status == rmb_pkg::RMB_BRAKE && low_side_switch_a |->
    low_side_switch_b && !high_side_switch_a && !high_side_switch_b) else $error("bad brake");
  AST_HOLD_KEEP: assert property (s_forward_released |-> ##1
    (mode_status == rmb_pkg::RMB_FORWARD)[*8]) else $error("standby entered without hold");
  AST_HOLD_END: assert property (low_cnt_reg == HOLD_CYC + 8 |->
    mode_status == rmb_pkg::RMB_STANDBY) else $error("hold too long");
  AST_BRAKE_EXIT: assert property (mode_status == rmb_pkg::RMB_BRAKE && both_low |->
    ##[1:4] mode_status == rmb_pkg::RMB_STANDBY) else $error("late standby from brake");
  AST_PULSE: assert property (ref_ratio == 8'hFF && $past(ref_ratio, 3) == 8'hFF
    && high_side_switch_a && $past(high_side_switch_a, 4) |->
    low_side_switch_a == $past(forward_direction_input, 3)) else $error("low a not following");
  AST_CROSS: assert property (!(high_side_switch_a && low_side_switch_b)
    && !(high_side_switch_b && low_side_switch_a)) else $error("cross conduction");
  AST_DEAD: assert property ($rose(high_side_switch_b) |-> since_a_reg >= 12'h2ED)
    else $error("dead time short");
  AST_SYNC: assert property (s_a_rise |-> $past(forward_direction_input, 3))
    else $error("high a rose without synchronised input");
endmodule

/* File: verif/reversible_motor_bridge_control_test.sv */
`timescale 1ns/1ps
module reversible_motor_bridge_control_test;
  localparam int HOLD = 6000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  rmb_pkg::rmb_mode_e host_mode = rmb_pkg::RMB_STANDBY;
  rmb_pkg::rmb_mode_e mode_status;
  rmb_pkg::rmb_mode_e applied;
  logic speed_pwm_en = 1'b0;
  logic [7:0] speed_duty = 8'h80;
  logic [7:0] ref_ratio = 8'hFF;
  logic hsa, lsa, hsb, lsb, a_lvl, a_fl, b_lvl, b_fl, act;
  logic [7:0] sw;
  int n_errors = 0;
  int n_checks = 0;
  rmb_link_if link();
  assign sw = {hsa, lsa, hsb, lsb, a_lvl, a_fl, b_lvl, b_fl};
  rmb_host_drive #(.DIR_GAP_CYC(100)) rmb_host_drive_inst (.clk(clk), .reset_n(reset_n),
    .link(link), .host_mode(host_mode), .speed_pwm_en(speed_pwm_en),
    .speed_duty(speed_duty), .applied_mode(applied));
  rmb_bridge_ctrl #(.HOLD_CYC(HOLD)) rmb_bridge_ctrl_inst (.clk(clk), .reset_n(reset_n),
    .link(link), .ref_ratio(ref_ratio), .high_side_switch_a(hsa), .low_side_switch_a(lsa),
    .high_side_switch_b(hsb), .low_side_switch_b(lsb), .bridge_output_a_level(a_lvl),
    .bridge_output_a_float(a_fl), .bridge_output_b_level(b_lvl), .bridge_output_b_float(b_fl),
    .circuits_active(act), .mode_status(mode_status));
  rmb_link_props #(.HOLD_CYC(HOLD)) rmb_link_props_inst (.clk(clk), .reset_n(reset_n),
    .forward_direction_input(link.forward_direction_input),
    .reverse_direction_input(link.reverse_direction_input), .ref_ratio(ref_ratio),
    .high_side_switch_a(hsa), .low_side_switch_a(lsa), .high_side_switch_b(hsb),
    .low_side_switch_b(lsb), .bridge_output_a_float(a_fl), .bridge_output_b_float(b_fl),
    .circuits_active(act), .mode_status(mode_status));
  initial
  begin
    forever #2 clk = ~clk;
  end
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task drive(input rmb_pkg::rmb_mode_e m, input int n);
    host_mode = m;
    tick(n);
  endtask
  // cycles with the pulsed low side on, checked against duty window
  task duty(input int n, input int exp, input int tol);
    int c;
    c = 0;
    repeat (n)
    begin
      tick(1);
      c += int'(lsa | lsb);
    end
    check("duty", 8'(c >= exp - tol && c <= exp + tol), 8'h01);
  endtask
  task t_static;
    rmb_pkg::rmb_mode_e m[3];
    logic [7:0] e[3];
    m = '{rmb_pkg::RMB_FORWARD, rmb_pkg::RMB_REVERSE, rmb_pkg::RMB_BRAKE};
    e = '{8'hC9, 8'h36, 8'h50};
    for (int i = 0; i < 3; i++)
    begin
      drive(m[i], 800);
      check("switches", sw, e[i]);
      check("mode", 8'({act, mode_status}), 8'({1'b1, m[i]}));
    end
    drive(rmb_pkg::RMB_STANDBY, 8);
    check("standby", sw, 8'h05);
    check("power", 8'({act, mode_status}), 8'h00);
  endtask
  task t_hold;
    // standby was taken 8 cycles ago: static direction gap holds forward off
    drive(rmb_pkg::RMB_FORWARD, 50);
    check("gap", 8'(applied), 8'h00);
    drive(rmb_pkg::RMB_FORWARD, 750);
    check("applied", 8'(applied), 8'h01);
    drive(rmb_pkg::RMB_STANDBY, HOLD - 100);
    check("held", 8'({act, mode_status}), 8'({1'b1, rmb_pkg::RMB_FORWARD}));
    check("held sw", sw, 8'h89);
    tick(200);
    check("after hold", sw, 8'h05);
    check("powered down", 8'({act, mode_status}), 8'h00);
  endtask
  // forward to reverse: 750 cycles all off, pattern on the next cycle
  task t_dead;
    drive(rmb_pkg::RMB_FORWARD, 800);
    drive(rmb_pkg::RMB_REVERSE, 753);
    check("dead sw", sw, 8'h05);
    check("dead mode", 8'({act, mode_status}), 8'h06);
    tick(1);
    check("after dead", sw, 8'h36);
  endtask
  // start from standby with low duty: line raised to 4D over 39-cycle steps
  task t_boost;
    int c;
    c = 0;
    drive(rmb_pkg::RMB_STANDBY, 10);
    speed_pwm_en = 1'b1;
    speed_duty = 8'h20;
    drive(rmb_pkg::RMB_FORWARD, 1);
    repeat (9984)
    begin
      tick(1);
      c += int'(link.forward_direction_input);
    end
    check("start duty", 8'(c == 3003), 8'h01);
  endtask
  task t_ref;
    ref_ratio = 8'h40;
    drive(rmb_pkg::RMB_FORWARD, 800);
    duty(9472, 2368, 40);
    ref_ratio = 8'h00;
    tick(10);
    duty(9472, 0, 0);
    ref_ratio = 8'hFF;
    tick(10);
  endtask
  task t_pwm;
    speed_pwm_en = 1'b1;
    speed_duty = 8'h80;
    tick(2000);
    duty(9984, 4992, 80);
    check("high a", 8'({hsa, hsb}), 8'h02);
    speed_duty = 8'hC0;
    drive(rmb_pkg::RMB_REVERSE, 2000);
    duty(9984, 7488, 80);
    check("high b", 8'({hsa, hsb}), 8'h01);
    speed_pwm_en = 1'b0;
  endtask
  initial
  begin
    tick(3);
    reset_n = 1'b1;
    tick(2);
    t_static();
    t_hold();
    t_dead();
    t_ref();
    t_pwm();
    t_boost();
    tally_and_finish();
  end
  initial
  begin
    #400000;
    n_errors++;
    tally_and_finish();
  end
endmodule
